// [bench/kbc_host_port_bench.sv]
// Self-checking bench for the keyboard controller host port
`timescale 1ns/1ps
`include "kbc_map.svh"
module kbc_host_port_bench;
   logic clk_i;
   logic resetn_i;
   logic [15:0] io_addr_i;
   logic io_rd_i;
   logic io_wr_i;
   logic [7:0] io_wdata_i;
   logic [7:0] io_rdata_o;
   logic irq_kbd_o;
   logic irq_mouse_o;
   logic kbd_clk_o;
   logic kbd_clk_oe_n_o;
   logic [7:0] mouse_data_i;
   logic mouse_valid_i;
   logic mouse_ready_o;
   logic mouse_disable_o;
   logic key_clk;
   logic key_data;
   logic kbd_clk_wire;
   logic [7:0] rd;
   logic mouse_took = 1'b0;
   int n_errors;
   int check_count;
   // Open-collector keyboard clock: the port pulls it low while inhibiting
   assign kbd_clk_wire = key_clk & (kbd_clk_oe_n_o | kbd_clk_o);
   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   kbc_host_port uut (
      .clk_i(clk_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
      .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .irq_kbd_o(irq_kbd_o), .irq_mouse_o(irq_mouse_o), .kbd_clk_i(kbd_clk_wire),
      .kbd_data_i(key_data), .kbd_clk_o(kbd_clk_o), .kbd_clk_oe_n_o(kbd_clk_oe_n_o),
      .mouse_data_i(mouse_data_i), .mouse_valid_i(mouse_valid_i),
      .mouse_ready_o(mouse_ready_o), .mouse_disable_o(mouse_disable_o));
   kbc_key_model kbd (.clk_i(clk_i), .kclk_line_i(kbd_clk_wire), .kclk_o(key_clk),
      .kdata_o(key_data));
   // Mouse side: sets mouse_took once the port takes the offered byte
   always @(posedge clk_i) begin
      if (mouse_valid_i && mouse_ready_o) begin
         mouse_took <= 1'b1;
      end
   end
   // Compare one value and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Single place where the run ends
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One-cycle read strobe; data is taken once the read edge has landed
   task automatic io_read(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_i);
      io_addr_i <= a;
      io_rd_i <= 1'b1;
      @(posedge clk_i);
      io_rd_i <= 1'b0;
      @(negedge clk_i);
      d = io_rdata_o;
   endtask
   // Poll status until the masked bits match, bounded
   task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
      logic [7:0] s;
      int i;
      s = 8'h00;
      for (i = 0; i < 300; i++) begin
         io_read(`KBC_CMD_PORT, s);
         if ((s & mask) === val) break;
      end
      if (i == 300) begin
         n_errors++;
         $display("ERROR at %0t: status %h never matched %h", $time, s, val);
         print_verdict();
      end
   endtask
   // One-cycle write strobe; data-port writes wait for an empty input buffer
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      if (a == `KBC_DATA_PORT) wait_stat(8'h02, 8'h00);
      @(posedge clk_i);
      io_addr_i <= a;
      io_wdata_i <= d;
      io_wr_i <= 1'b1;
      @(posedge clk_i);
      io_wr_i <= 1'b0;
   endtask
   // Good keystroke, then a few cycles for it to reach the queue
   task automatic key(input logic [7:0] b);
      kbd.send_byte(b, 1'b0);
      repeat (6) @(posedge clk_i);
   endtask
   // Command whose answer lands in the output buffer, then read it back
   task automatic ask(input logic [7:0] op, input logic [7:0] exp);
      io_write(`KBC_CMD_PORT, op);
      wait_stat(8'h01, 8'h01);
      io_read(`KBC_DATA_PORT, rd);
      check(rd, exp);
   endtask
   initial begin
      resetn_i = 1'b0;
      io_addr_i = 16'h0000;
      io_rd_i = 1'b0;
      io_wr_i = 1'b0;
      io_wdata_i = 8'h00;
      mouse_data_i = 8'h00;
      mouse_valid_i = 1'b0;
      n_errors = 0;
      check_count = 0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      // Reset state, status port, command decode
      io_read(`KBC_CMD_PORT, rd);
      check(rd, 8'h00);
      ask(`KBC_OP_RD_CFG, `KBC_CFG_RESET);
      io_write(`KBC_DATA_PORT, 8'h33);
      io_write(`KBC_CMD_PORT, `KBC_OP_AUX_OFF);
      repeat (2) @(posedge clk_i);
      io_read(`KBC_CMD_PORT, rd);
      check(rd & 8'h09, 8'h08);
      check({7'h00, mouse_disable_o}, 8'h01);
      io_write(`KBC_CMD_PORT, `KBC_OP_AUX_ON);
      $display("Test reset and decode done");
      // No password stored: absent answer, enable refused
      ask(`KBC_OP_PW_TEST, `KBC_ANS_PW_ABSENT);
      io_write(`KBC_CMD_PORT, `KBC_OP_PW_ENABLE);
      repeat (2) @(posedge clk_i);
      io_read(`KBC_CMD_PORT, rd);
      check(rd & 8'h10, 8'h00);
      $display("Test no password done");
      // Keyboard bytes with the keyboard interrupt enabled
      io_write(`KBC_CMD_PORT, `KBC_OP_WR_CFG);
      io_write(`KBC_DATA_PORT, 8'h41);
      key(8'h1C);
      wait_stat(8'h01, 8'h01);
      check({7'h00, irq_kbd_o}, 8'h01);
      io_read(`KBC_DATA_PORT, rd);
      check(rd, 8'h1C);
      check({7'h00, irq_kbd_o}, 8'h00);
      key(`KBC_BREAK_CODE);
      key(8'h1C);
      wait_stat(8'h01, 8'h01);
      io_read(`KBC_DATA_PORT, rd);
      check(rd, 8'h9C);
      kbd.send_byte(8'h2A, 1'b1);
      repeat (20) @(posedge clk_i);
      io_read(`KBC_CMD_PORT, rd);
      check(rd & 8'h81, 8'h80);
      $display("Test keyboard bytes done");
      // Load a password, then replace it with a second one
      io_write(`KBC_CMD_PORT, `KBC_OP_PW_LOAD);
      io_write(`KBC_DATA_PORT, 8'h11);
      io_write(`KBC_DATA_PORT, `KBC_PW_END);
      io_write(`KBC_CMD_PORT, `KBC_OP_PW_LOAD);
      io_write(`KBC_DATA_PORT, 8'h1C);
      io_write(`KBC_DATA_PORT, 8'h32);
      io_write(`KBC_DATA_PORT, `KBC_PW_END);
      ask(`KBC_OP_PW_TEST, `KBC_ANS_PW_PRESENT);
      $display("Test password load done");
      // Secure mode: nothing passes, commands ignored, restart on a wrong key
      io_write(`KBC_CMD_PORT, `KBC_OP_PW_ENABLE);
      repeat (2) @(posedge clk_i);
      io_read(`KBC_CMD_PORT, rd);
      check(rd & 8'h10, 8'h10);
      @(posedge clk_i);
      mouse_data_i <= 8'h5A;
      mouse_valid_i <= 1'b1;
      io_write(`KBC_CMD_PORT, `KBC_OP_PW_TEST);
      key(8'h11);
      key(8'h1C);
      key(8'h33);
      key(8'h32);
      io_read(`KBC_CMD_PORT, rd);
      check(rd & 8'h31, 8'h10);
      @(negedge clk_i);
      check({7'h00, mouse_ready_o}, 8'h00);
      check({7'h00, mouse_took}, 8'h00);
      key(8'h1C);
      key(8'h32);
      repeat (4) @(posedge clk_i);
      io_read(`KBC_CMD_PORT, rd);
      check(rd & 8'h10, 8'h00);
      // Held mouse byte is the first thing to reach the host
      for (int i = 0; i < 50 && mouse_took !== 1'b1; i++) begin
         @(posedge clk_i);
      end
      check({7'h00, mouse_took}, 8'h01);
      @(posedge clk_i);
      mouse_valid_i <= 1'b0;
      wait_stat(8'h21, 8'h21);
      check({7'h00, irq_mouse_o}, 8'h00);
      io_read(`KBC_DATA_PORT, rd);
      check(rd, 8'h5A);
      $display("Test secure mode done");
      print_verdict();
   end
endmodule // kbc_host_port_bench

// [bench/kbc_key_model.sv]
// Behavioural keyboard that sends serial frames toward the host port
`timescale 1ns/1ps
module kbc_key_model (
   // Clock used to pace the frames
   input wire logic clk_i,
   // Keyboard clock as seen on the wire
   input wire logic kclk_line_i,
   // Open-collector lines, released to the pull-up between frames
   output logic kclk_o,
   output logic kdata_o
);
   // Both lines rest high until a frame starts
   initial begin
      kclk_o = 1'b1;
      kdata_o = 1'b1;
   end
   // Frame: start 0, data LSB first, odd parity, stop 1; bad flips the parity
   task automatic send_byte(input logic [7:0] b, input logic bad);
      logic [10:0] f;
      f = {1'b1, (~^b) ^ bad, b, 1'b0};
      // The port may be inhibiting; wait for the clock to be let go, bounded
      for (int i = 0; i < 1000 && kclk_line_i !== 1'b1; i++) begin
         @(posedge clk_i);
      end
      // Four cycles low and five high per bit keep the synchroniser comfortably fed
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_i);
         kdata_o <= f[i];
         repeat (4) @(posedge clk_i);
         kclk_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         kclk_o <= 1'b1;
      end
      @(posedge clk_i);
      kdata_o <= 1'b1;
   endtask
endmodule // kbc_key_model

// [core/kbc_fifo.sv]
// Keyboard byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module kbc_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Both sides of the queue
   kbc_fifo_if.store q
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } kbc_fifo_state_type;
   kbc_fifo_state_type cur_ff;
   kbc_fifo_state_type nxt_cur;
   logic push;
   logic pop;

   // Full and empty come straight from the held count
   assign q.wr_ready = (cur_ff.cnt != (AW+1)'(D));
   assign q.rd_valid = (cur_ff.cnt != '0);
   assign q.rd_data = cur_ff.mem[cur_ff.rp];
   assign push = q.wr_valid && q.wr_ready;
   assign pop = q.rd_valid && q.rd_ready;

   // Pointer and count update
   always_comb begin
      nxt_cur = cur_ff;
      if (push) begin
         nxt_cur.mem[cur_ff.wp] = q.wr_data;
         nxt_cur.wp = (cur_ff.wp == AW'(D-1)) ? '0 : cur_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_cur.rp = (cur_ff.rp == AW'(D-1)) ? '0 : cur_ff.rp + 1'b1;
      end
      if (push && !pop) begin
         nxt_cur.cnt = cur_ff.cnt + 1'b1;
      end else if (pop && !push) begin
         nxt_cur.cnt = cur_ff.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   a_fifo_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cur_ff.cnt <= (AW+1)'(D)) else $error("fifo count beyond depth");
endmodule // kbc_fifo

// [core/kbc_host_port.sv]
// Keyboard controller host port: receiver, command decoder and password lock
`timescale 1ns/1ps
`include "kbc_map.svh"
module kbc_host_port (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Host I/O cycle
   input wire logic [15:0] io_addr_i,
   input wire logic io_rd_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   // Interrupts to the host
   output logic irq_kbd_o,
   output logic irq_mouse_o,
   // Keyboard serial pins
   input wire logic kbd_clk_i,
   input wire logic kbd_data_i,
   output logic kbd_clk_o,
   output logic kbd_clk_oe_n_o,
   // Mouse bytes from the mouse receiver
   input wire logic [7:0] mouse_data_i,
   input wire logic mouse_valid_i,
   output logic mouse_ready_o,
   // Configuration lines toward the mouse side
   output logic mouse_disable_o
);
   typedef struct packed {
      logic kclk_s1;
      logic kclk_s2;
      logic kdat_s1;
      logic kdat_s2;
      logic kclk_q;
      kbc_pkg::kbc_rx_state_type rx_st;
      logic [3:0] rx_cnt;
      logic [9:0] rx_sh;
      logic brk;
      logic perr;
      kbc_pkg::kbc_cmd_state_type cmd_st;
      logic [7:0] cfg;
      logic obf;
      logic aux;
      logic [7:0] obuf;
      logic resp_pend;
      logic [7:0] resp;
      logic cd;
      logic ibf;
      logic [7:0] rdata;
      logic [`KBC_PW_DEPTH-1:0][7:0] pw;
      logic [3:0] pw_len;
      logic [3:0] pw_idx;
      logic secure;
   } kbc_state_type;

   kbc_state_type cur_ff;
   kbc_state_type nxt_cur;
   kbc_fifo_if #(.W(8)) kq ();

   logic wr_data_port;
   logic wr_cmd_port;
   logic rd_data_port;
   logic rd_cmd_port;
   logic kfall;
   logic rx_done;
   logic rx_par_ok;
   logic [7:0] rx_byte;
   logic [7:0] pw_cur;
   logic [7:0] pw_first;
   logic out_free;
   logic [7:0] status;

   kbc_fifo #(
      .W(8),
      .D(`KBC_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .q(kq.store)
   );

   // Port decode of the host cycle
   assign wr_data_port = io_wr_i && (io_addr_i == `KBC_DATA_PORT);
   assign wr_cmd_port = io_wr_i && (io_addr_i == `KBC_CMD_PORT);
   assign rd_data_port = io_rd_i && (io_addr_i == `KBC_DATA_PORT);
   assign rd_cmd_port = io_rd_i && (io_addr_i == `KBC_CMD_PORT);

   // Frame decode: falling keyboard clock after synchronising, odd parity
   assign kfall = cur_ff.kclk_q && !cur_ff.kclk_s2;
   assign rx_done = kfall && (cur_ff.rx_st == kbc_pkg::KBC_RX_BITS) &&
                    (cur_ff.rx_cnt == `KBC_FRAME_BITS - 4'h1);
   // At the stop edge nine bits have shifted in: data in [8:1], parity in [9]
   assign rx_byte = cur_ff.rx_sh[8:1];
   assign rx_par_ok = ^cur_ff.rx_sh[9:1];

   // Password bytes under comparison
   assign pw_cur = cur_ff.pw[cur_ff.pw_idx[2:0]];
   assign pw_first = cur_ff.pw[0];

   // Output buffer may be refilled only while empty and not locked
   assign out_free = !cur_ff.obf && !cur_ff.secure;

   // Status byte as the host sees it on the command port
   assign status = {cur_ff.perr, 1'b0, cur_ff.obf && cur_ff.aux, cur_ff.secure,
                    cur_ff.cd, cur_ff.cfg[`KBC_CFG_SYSF], cur_ff.ibf, cur_ff.obf};

   // Handshakes: pending answers first, then keys, then mouse
   assign kq.rd_ready = out_free && !cur_ff.resp_pend;
   assign mouse_ready_o = out_free && !cur_ff.resp_pend && !kq.rd_valid;

   // Keyboard clock is held low when the queue is full or keys are disabled
   assign kbd_clk_o = 1'b0;
   assign kbd_clk_oe_n_o = kq.wr_ready && !cur_ff.cfg[`KBC_CFG_KDIS];
   assign mouse_disable_o = cur_ff.cfg[`KBC_CFG_MDIS];

   // Interrupt lines follow the full buffer when enabled; otherwise host polls
   assign irq_kbd_o = cur_ff.obf && !cur_ff.aux && cur_ff.cfg[`KBC_CFG_KIRQ];
   assign irq_mouse_o = cur_ff.obf && cur_ff.aux && cur_ff.cfg[`KBC_CFG_MIRQ];
   assign io_rdata_o = cur_ff.rdata;

   // Next state of the whole controller
   always_comb begin
      nxt_cur = cur_ff;
      kq.wr_valid = 1'b0;
      kq.wr_data = rx_byte;
      // Two-stage synchronisers; stage two and its delayed copy kclk_q feed logic
      nxt_cur.kclk_s1 = kbd_clk_i;
      nxt_cur.kclk_s2 = cur_ff.kclk_s1;
      nxt_cur.kdat_s1 = kbd_data_i;
      nxt_cur.kdat_s2 = cur_ff.kdat_s1;
      nxt_cur.kclk_q = cur_ff.kclk_s2;
      nxt_cur.ibf = io_wr_i; // Each write is consumed in one cycle

      // Serial receiver: start, eight data, parity, stop
      case (cur_ff.rx_st)
         kbc_pkg::KBC_RX_IDLE: begin
            if (kfall && !cur_ff.kdat_s2) begin
               nxt_cur.rx_st = kbc_pkg::KBC_RX_BITS;
               nxt_cur.rx_cnt = 4'h0;
            end
         end
         kbc_pkg::KBC_RX_BITS: begin
            if (kfall) begin
               nxt_cur.rx_sh = {cur_ff.kdat_s2, cur_ff.rx_sh[9:1]};
               nxt_cur.rx_cnt = cur_ff.rx_cnt + 4'h1;
               if (rx_done) begin
                  nxt_cur.rx_st = kbc_pkg::KBC_RX_IDLE;
               end
            end
         end
         default: begin
            nxt_cur.rx_st = kbc_pkg::KBC_RX_IDLE;
         end
      endcase

      // Completed frame: parity, lock comparison or translation
      if (rx_done) begin
         nxt_cur.perr = !rx_par_ok;
         if (rx_par_ok && cur_ff.secure) begin
            // Keys go to the comparator and never to the host
            if (rx_byte == pw_cur) begin
               if (cur_ff.pw_idx + 4'h1 == cur_ff.pw_len) begin
                  nxt_cur.secure = 1'b0;
                  nxt_cur.pw_idx = 4'h0;
               end else begin
                  nxt_cur.pw_idx = cur_ff.pw_idx + 4'h1;
               end
            end else begin
               nxt_cur.pw_idx = (rx_byte == pw_first) ? 4'h1 : 4'h0;
            end
         end else if (rx_par_ok && cur_ff.cfg[`KBC_CFG_XLAT] &&
                      rx_byte == `KBC_BREAK_CODE) begin
            nxt_cur.brk = 1'b1; // Break prefix folds into the next code
         end else if (rx_par_ok) begin
            kq.wr_valid = 1'b1;
            if (cur_ff.cfg[`KBC_CFG_XLAT] && cur_ff.brk) begin
               kq.wr_data = rx_byte | `KBC_BREAK_BIT;
            end
            nxt_cur.brk = 1'b0;
         end
      end

      // Host reads: data pops the buffer, command port shows status
      if (rd_data_port) begin
         nxt_cur.rdata = cur_ff.obuf;
         nxt_cur.obf = 1'b0;
      end else if (rd_cmd_port) begin
         nxt_cur.rdata = status;
      end

      // Refill the output buffer; a byte stays until read
      if (out_free && cur_ff.resp_pend) begin
         nxt_cur.obf = 1'b1;
         nxt_cur.aux = 1'b0;
         nxt_cur.obuf = cur_ff.resp;
         nxt_cur.resp_pend = 1'b0;
      end else if (kq.rd_valid && kq.rd_ready) begin
         nxt_cur.obf = 1'b1;
         nxt_cur.aux = 1'b0;
         nxt_cur.obuf = kq.rd_data;
      end else if (mouse_valid_i && mouse_ready_o) begin
         nxt_cur.obf = 1'b1;
         nxt_cur.aux = 1'b1;
         nxt_cur.obuf = mouse_data_i;
      end

      // Host writes: command port decodes, data port feeds pending command
      if (io_wr_i) begin
         nxt_cur.cd = wr_cmd_port;
      end
      if (wr_cmd_port && !cur_ff.secure) begin // Locked port takes no command
         nxt_cur.cmd_st = kbc_pkg::KBC_CMD_IDLE;
         if (io_wdata_i == `KBC_OP_RD_CFG) begin
            nxt_cur.resp_pend = 1'b1;
            nxt_cur.resp = cur_ff.cfg;
         end else if (io_wdata_i == `KBC_OP_WR_CFG) begin
            nxt_cur.cmd_st = kbc_pkg::KBC_CMD_WCFG;
         end else if (io_wdata_i == `KBC_OP_PW_TEST) begin
            nxt_cur.resp_pend = 1'b1;
            nxt_cur.resp = (cur_ff.pw_len != 4'h0) ?
                           `KBC_ANS_PW_PRESENT : `KBC_ANS_PW_ABSENT;
         end else if (io_wdata_i == `KBC_OP_PW_LOAD) begin
            nxt_cur.pw_len = 4'h0; // Old pattern is gone at once
            nxt_cur.cmd_st = kbc_pkg::KBC_CMD_LOAD;
         end else if (io_wdata_i == `KBC_OP_PW_ENABLE) begin
            if (cur_ff.pw_len != 4'h0) begin
               nxt_cur.secure = 1'b1;
               nxt_cur.pw_idx = 4'h0;
            end
         end else if (io_wdata_i == `KBC_OP_AUX_OFF) begin
            nxt_cur.cfg[`KBC_CFG_MDIS] = 1'b1;
         end else if (io_wdata_i == `KBC_OP_AUX_ON) begin
            nxt_cur.cfg[`KBC_CFG_MDIS] = 1'b0;
         end else if (io_wdata_i == `KBC_OP_SELF_TEST) begin
            nxt_cur.resp_pend = 1'b1;
            nxt_cur.resp = `KBC_ANS_SELF_OK;
         end
         // Any other code, readback of the password included, does nothing
      end else if (wr_data_port && !cur_ff.secure) begin
         // Data bytes are taken on trust that the host waited for input-empty
         case (cur_ff.cmd_st)
            kbc_pkg::KBC_CMD_WCFG: begin
               nxt_cur.cfg = io_wdata_i;
               nxt_cur.cmd_st = kbc_pkg::KBC_CMD_IDLE;
            end
            kbc_pkg::KBC_CMD_LOAD: begin
               // Pattern is stored as sent; host supplies scan codes
               if (io_wdata_i == `KBC_PW_END) begin
                  nxt_cur.cmd_st = kbc_pkg::KBC_CMD_IDLE;
               end else if (cur_ff.pw_len != 4'(`KBC_PW_DEPTH)) begin
                  nxt_cur.pw[cur_ff.pw_len[2:0]] = io_wdata_i;
                  nxt_cur.pw_len = cur_ff.pw_len + 4'h1;
               end
            end
            default: begin
               nxt_cur.cmd_st = kbc_pkg::KBC_CMD_IDLE;
            end
         endcase
      end
   end

   // State register; a locked controller keeps every other setting intact
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cur_ff <= '0;
         cur_ff.kclk_s1 <= 1'b1;
         cur_ff.kclk_s2 <= 1'b1;
         cur_ff.kclk_q <= 1'b1;
         cur_ff.kdat_s1 <= 1'b1;
         cur_ff.kdat_s2 <= 1'b1;
         cur_ff.cfg <= `KBC_CFG_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   a_pw_query_answer: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_cmd_port && !cur_ff.secure && io_wdata_i == `KBC_OP_PW_TEST) |=>
      cur_ff.resp_pend && cur_ff.resp == ((cur_ff.pw_len != 4'h0) ?
      `KBC_ANS_PW_PRESENT : `KBC_ANS_PW_ABSENT))
      else $error("password query answer wrong");

   a_lock_needs_pw: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(cur_ff.secure) |-> cur_ff.pw_len != 4'h0)
      else $error("secure mode without password");

   a_lock_withholds: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cur_ff.secure && !$past(cur_ff.secure) |-> !kq.rd_ready && !mouse_ready_o ##1
      (!cur_ff.obf || $stable(cur_ff.obuf)))
      else $error("data passed while locked");

   a_lock_cmd_ignore: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cur_ff.secure && io_wr_i) |=> $stable(cur_ff.cfg) && $stable(cur_ff.cmd_st) &&
      $stable(cur_ff.pw_len))
      else $error("command taken while locked");

   a_load_clears_pw: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_cmd_port && !cur_ff.secure && io_wdata_i == `KBC_OP_PW_LOAD) |=>
      cur_ff.pw_len == 4'h0 && cur_ff.cmd_st == kbc_pkg::KBC_CMD_LOAD)
      else $error("password load did not start");

   a_zero_ends_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_data_port && !cur_ff.secure && cur_ff.cmd_st == kbc_pkg::KBC_CMD_LOAD &&
      io_wdata_i == `KBC_PW_END) |=> cur_ff.cmd_st == kbc_pkg::KBC_CMD_IDLE &&
      $stable(cur_ff.pw_len))
      else $error("zero byte did not end load");

   a_status_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_cmd_port |=> io_rdata_o == $past(status))
      else $error("status read wrong");

   a_data_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (rd_data_port && cur_ff.obf) |=> io_rdata_o == $past(cur_ff.obuf) && !cur_ff.obf)
      else $error("data read wrong");

   a_match_unlocks: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (rx_done && rx_par_ok && cur_ff.secure && rx_byte == pw_cur &&
      cur_ff.pw_idx + 4'h1 == cur_ff.pw_len) |=> !cur_ff.secure)
      else $error("match did not unlock");

   a_parity_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (rx_done && !rx_par_ok) |=> cur_ff.perr ##1 1'b1)
      else $error("parity error not flagged");
endmodule // kbc_host_port

// [inc/kbc_fifo_if.sv]
// Valid/ready carrier between the host port and its keyboard byte FIFO
`timescale 1ns/1ps
interface kbc_fifo_if #(parameter int W = 8);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;
   modport ctrl (output wr_valid, output wr_data, input wr_ready,
                 input rd_valid, input rd_data, output rd_ready);
   modport store (input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready);
endinterface

// [inc/kbc_map.svh]
// Port addresses, command codes, field positions and reset values of the host port
// How it works
// - Receive keyboard bytes, check parity, translate codes
// - Each keyboard byte with good parity readable at data port, F0 prefix folded when translating
// - Raise interrupt when enabled, else hold byte
// - Reading command port returns status byte
// - Bytes written to command port are commands
// - Test-password command reports password presence
// - Presence answer is FA, absence F1
// - Load-password discards old password, anytime outside secure mode
// - Password bytes via data port, zero ends
// - Enable-security enters secure mode, nothing forwarded
// - Secure mode only with stored password
// - Secure mode compares key stream to password
// - No keyboard or mouse data until match
// - Full match restores state, resumes forwarding
// - No password readback; replace any number times
// - All host commands ignored while secure
`ifndef KBC_MAP_SVH
`define KBC_MAP_SVH
`define KBC_DATA_PORT 16'h0060
`define KBC_CMD_PORT 16'h0064
`define KBC_OP_RD_CFG 8'h20
`define KBC_OP_WR_CFG 8'h60
`define KBC_OP_PW_TEST 8'hA4
`define KBC_OP_PW_LOAD 8'hA5
`define KBC_OP_PW_ENABLE 8'hA6
`define KBC_OP_AUX_OFF 8'hA7
`define KBC_OP_AUX_ON 8'hA8
`define KBC_OP_SELF_TEST 8'hAA
`define KBC_ANS_PW_PRESENT 8'hFA
`define KBC_ANS_PW_ABSENT 8'hF1
`define KBC_ANS_SELF_OK 8'h55
`define KBC_PW_END 8'h00
`define KBC_BREAK_CODE 8'hF0
`define KBC_BREAK_BIT 8'h80
`define KBC_CFG_RESET 8'h40
`define KBC_CFG_KIRQ 0
`define KBC_CFG_MIRQ 1
`define KBC_CFG_SYSF 2
`define KBC_CFG_KDIS 4
`define KBC_CFG_MDIS 5
`define KBC_CFG_XLAT 6
`define KBC_PW_DEPTH 8
`define KBC_FIFO_DEPTH 8
`define KBC_FRAME_BITS 4'hA
`endif

// [inc/kbc_pkg.sv]
// Types shared by the keyboard controller host port
package kbc_pkg;
   typedef enum logic [1:0] {
      KBC_CMD_IDLE = 2'b00,
      KBC_CMD_WCFG = 2'b01,
      KBC_CMD_LOAD = 2'b10
   } kbc_cmd_state_type;
   typedef enum logic {
      KBC_RX_IDLE = 1'b0,
      KBC_RX_BITS = 1'b1
   } kbc_rx_state_type;
endpackage
